// ### design/cssc_pkg.sv
package cssc_pkg;

  // ----------------------------------------------------------------
  // Factory fuse values and fuse meaning
  // ----------------------------------------------------------------
  localparam logic [3:0] FACTORY_SOURCE_SELECT = 4'h1;
  localparam logic [1:0] FACTORY_STARTUP_TIME  = 2'h2;
  localparam logic       FUSE_PROGRAMMED       = 1'b0;
  localparam logic       FUSE_UNPROGRAMMED     = 1'b1;

  // ----------------------------------------------------------------
  // Start-up counts, in cycles of the counting clock
  // ----------------------------------------------------------------
  localparam int CNT_W            = 17;
  localparam int SRC_CYCLES_6     = 6;
  localparam int SRC_CYCLES_18    = 18;
  localparam int SRC_CYCLES_258   = 258;
  localparam int SRC_CYCLES_1K    = 1024;
  localparam int SRC_CYCLES_16K   = 16384;
  localparam int SRC_CYCLES_32K   = 32768;
  localparam int WDOG_CYCLES_4K   = 4096;
  localparam int WDOG_CYCLES_64K  = 65536;

  // ----------------------------------------------------------------
  // Register map and field positions
  // ----------------------------------------------------------------
  localparam int         ADDR_W          = 8;
  localparam logic [7:0] REG_CTRL_OFS    = 8'h00;
  localparam logic [7:0] REG_STATUS_OFS  = 8'h04;
  localparam int         CTRL_SLEEP_BIT  = 0;
  localparam int         CTRL_MODE_LSB   = 1;
  localparam int         CTRL_ASYNC_BIT  = 4;
  localparam int         CTRL_CONV_BIT   = 5;
  localparam logic [2:0] CTRL_MODE_RESET = 3'h0;

  // Sleep modes
  localparam logic [2:0] SLEEP_IDLE       = 3'h0;
  localparam logic [2:0] SLEEP_NOISE_RED  = 3'h1;
  localparam logic [2:0] SLEEP_POWER_DOWN = 3'h2;
  localparam logic [2:0] SLEEP_POWER_SAVE = 3'h3;
  localparam logic [2:0] SLEEP_STANDBY    = 3'h6;

  typedef enum logic [2:0] {
    SRC_CRYSTAL, SRC_LOW_FREQ, SRC_EXT_RC, SRC_INT_RC, SRC_EXT_CLOCK
  } cssc_source_t;

  typedef enum logic [2:0] {
    RANGE_NONE, RANGE_0_4_TO_0_9, RANGE_0_9_TO_3_0, RANGE_3_0_TO_8_0, RANGE_1_0_UP
  } cssc_range_t;

  typedef struct packed {
    logic [2:0] sleep_mode;
    logic       async_timer_enable;
    logic       converter_enable;
  } cssc_ctrl_t;

  typedef struct packed {
    logic core_clock;
    logic peripheral_clock;
    logic program_memory_clock;
    logic async_timer_clock;
    logic converter_clock;
  } cssc_clk_en_t;

endpackage

// ### design/cssc_startup_counter.sv
`timescale 1ns/1ns
`default_nettype none
module cssc_startup_counter
  import cssc_pkg::*;
#(
  parameter int W = CNT_W
) (
  input  wire logic         i_clk,    // System clock
  input  wire logic         i_rst,    // Sync reset, active high
  input  wire logic         i_load,   // Start a new count
  input  wire logic [W-1:0] i_value,  // Cycles to count
  input  wire logic         i_tick,   // One counting-clock cycle
  output logic              o_done    // Count elapsed, idle
);

  logic [W-1:0] remaining;
  logic         busy;

  // Counting stops when the last tick takes the count to zero; a zero load finishes at once
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      remaining <= '0;
      busy      <= 1'b0;
    end else if (i_load) begin
      remaining <= i_value;
      busy      <= (i_value != '0);
    end else if (busy && i_tick) begin
      remaining <= remaining - 1'b1;
      busy      <= (remaining != W'(1));
    end
  end

  assign o_done = !busy;

endmodule // cssc_startup_counter
`default_nettype wire

// ### design/cssc_wb_regs.sv
`timescale 1ns/1ns
`default_nettype none
module cssc_wb_regs
  import cssc_pkg::*;
(
  input  wire logic              i_clk,           // System clock
  input  wire logic              i_rst,           // Sync reset, active high
  input  wire logic              i_wb_cyc,        // Bus cycle
  input  wire logic              i_wb_stb,        // Strobe
  input  wire logic              i_wb_we,         // Write enable
  input  wire logic [ADDR_W-1:0] i_wb_adr,        // Byte address
  input  wire logic [31:0]       i_wb_dat,        // Write data
  input  wire logic [3:0]        i_wb_sel,        // Byte enables
  input  wire logic [31:0]       i_status,        // Live status word
  output logic [31:0]            o_wb_dat,        // Read data
  output logic                   o_wb_ack,        // Acknowledge
  output cssc_ctrl_t             o_ctrl,          // Control fields
  output logic                   o_sleep_request  // One-cycle sleep pulse
);

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire logic take      = i_wb_cyc && i_wb_stb && !o_wb_ack;
  wire logic hit_ctrl  = (i_wb_adr == REG_CTRL_OFS);
  wire logic hit_stat  = (i_wb_adr == REG_STATUS_OFS);
  wire logic wr_ctrl   = take && i_wb_we && hit_ctrl && i_wb_sel[0];
  wire logic [31:0] ctrl_word = {26'h000_0000, o_ctrl.converter_enable,
                                 o_ctrl.async_timer_enable, o_ctrl.sleep_mode, 1'b0};
  wire logic [31:0] read_mux = hit_ctrl ? ctrl_word :
                               hit_stat ? i_status : 32'h0000_0000;

  // Ack one cycle after the strobe, dropped the cycle after
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0000_0000;
    end else begin
      o_wb_ack <= take;
      o_wb_dat <= (take && !i_wb_we) ? read_mux : 32'h0000_0000;
    end
  end

  // Control fields; the sleep bit is a self-clearing command
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_ctrl          <= '{sleep_mode: CTRL_MODE_RESET, default: 1'b0};
      o_sleep_request <= 1'b0;
    end else begin
      o_sleep_request <= wr_ctrl && i_wb_dat[CTRL_SLEEP_BIT];
      if (wr_ctrl) begin
        o_ctrl.sleep_mode         <= i_wb_dat[CTRL_MODE_LSB +: 3];
        o_ctrl.async_timer_enable <= i_wb_dat[CTRL_ASYNC_BIT];
        o_ctrl.converter_enable   <= i_wb_dat[CTRL_CONV_BIT];
      end
    end
  end

endmodule // cssc_wb_regs
`default_nettype wire

// ### design/cssc_clock_control.sv
`timescale 1ns/1ns
`default_nettype none
module cssc_clock_control
  import cssc_pkg::*;
#(
  parameter int SRC_16K_CYCLES  = SRC_CYCLES_16K,   // Long crystal start-up
  parameter int SRC_32K_CYCLES  = SRC_CYCLES_32K,   // Watch crystal start-up
  parameter int WDOG_4K_CYCLES  = WDOG_CYCLES_4K,   // Short reset delay
  parameter int WDOG_64K_CYCLES = WDOG_CYCLES_64K   // Long reset delay
) (
  input  wire logic              i_clk,                         // System clock
  input  wire logic              i_rst,                         // Sync reset, active high
  input  wire logic [3:0]        i_clock_source_select_fuses,   // Source fuses
  input  wire logic [1:0]        i_startup_time_fuses,          // Start-up fuses
  input  wire logic              i_oscillator_amplifier_option, // Amplifier fuse
  input  wire logic              i_source_tick,                 // Selected source cycle
  input  wire logic              i_watchdog_tick,               // Watchdog osc cycle
  input  wire logic              i_wake_event,                  // Wake from sleep
  input  wire logic              i_wb_cyc,                      // Wishbone cycle
  input  wire logic              i_wb_stb,                      // Wishbone strobe
  input  wire logic              i_wb_we,                       // Wishbone write
  input  wire logic [ADDR_W-1:0] i_wb_adr,                      // Wishbone address
  input  wire logic [31:0]       i_wb_dat,                      // Wishbone write data
  input  wire logic [3:0]        i_wb_sel,                      // Wishbone byte lanes
  output logic [31:0]            o_wb_dat,                      // Wishbone read data
  output logic                   o_wb_ack,                      // Wishbone ack
  output cssc_clk_en_t           o_clk_en,                      // Domain clock enables
  output logic                   o_core_run,                    // Fetch released
  output logic                   o_async_detect_arm,            // Async wake logic armed
  output cssc_source_t           o_source_kind,                 // Decoded source
  output cssc_range_t            o_freq_range                   // Crystal range
);

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------

  // Source kind from the four select fuses
  function automatic cssc_source_t decode_source(input logic [3:0] sel);
    if (sel >= 4'hA)
      decode_source = SRC_CRYSTAL;
    else if (sel == 4'h9)
      decode_source = SRC_LOW_FREQ;
    else if (sel >= 4'h5)
      decode_source = SRC_EXT_RC;
    else if (sel >= 4'h1)
      decode_source = SRC_INT_RC;
    else
      decode_source = SRC_EXT_CLOCK;
  endfunction

  // Crystal frequency range; a zero amplifier fuse means programmed
  function automatic cssc_range_t decode_range(input logic [3:0] sel,
                                               input logic       amp);
    decode_range = RANGE_NONE;
    if (decode_source(sel) == SRC_CRYSTAL) begin
      if (amp == FUSE_PROGRAMMED) begin
        decode_range = RANGE_1_0_UP;
      end else begin
        case (sel[3:1])
          3'h5:    decode_range = RANGE_0_4_TO_0_9;
          3'h6:    decode_range = RANGE_0_9_TO_3_0;
          3'h7:    decode_range = RANGE_3_0_TO_8_0;
          default: decode_range = RANGE_NONE;
        endcase
      end
    end
  endfunction

  // Source-cycle start-up count for the fuse setting
  function automatic logic [CNT_W-1:0] source_delay(input logic [3:0] sel,
                                                     input logic [1:0] startup_time_fuses);
    source_delay = CNT_W'(SRC_CYCLES_6);
    case (decode_source(sel))
      SRC_CRYSTAL: begin
        if (sel[0] == 1'b0)
          source_delay = startup_time_fuses[1] ? CNT_W'(SRC_CYCLES_1K) : CNT_W'(SRC_CYCLES_258);
        else
          source_delay = (startup_time_fuses == 2'h0) ? CNT_W'(SRC_CYCLES_1K)
                                       : CNT_W'(SRC_16K_CYCLES);
      end
      SRC_LOW_FREQ:
        source_delay = startup_time_fuses[1] ? CNT_W'(SRC_32K_CYCLES) : CNT_W'(SRC_CYCLES_1K);
      SRC_EXT_RC:
        source_delay = (startup_time_fuses == 2'h3) ? CNT_W'(SRC_CYCLES_6) : CNT_W'(SRC_CYCLES_18);
      default:
        source_delay = CNT_W'(SRC_CYCLES_6);
    endcase
  endfunction

  // Reserved start-up codes take the long delay, the safe side, except the short one for even crystal selects
  // Watchdog-cycle reset delay; zero means no extra delay
  function automatic logic [CNT_W-1:0] reset_delay(input logic [3:0] sel,
                                                    input logic [1:0] startup_time_fuses);
    logic [1:0] code; // 0 none, 1 short, 2 long
    code = 2'h0;
    case (decode_source(sel))
      SRC_CRYSTAL: begin
        if (sel[0] == 1'b0) begin
          case (startup_time_fuses)
            2'h0:    code = 2'h1;
            2'h1:    code = 2'h2;
            2'h2:    code = 2'h0;
            default: code = 2'h1;
          endcase
        end else begin
          case (startup_time_fuses)
            2'h0:    code = 2'h2;
            2'h1:    code = 2'h0;
            2'h2:    code = 2'h1;
            default: code = 2'h2;
          endcase
        end
      end
      SRC_LOW_FREQ:
        code = (startup_time_fuses == 2'h0) ? 2'h1 : 2'h2;
      SRC_EXT_RC:
        code = (startup_time_fuses == 2'h0) ? 2'h0 : (startup_time_fuses == 2'h2) ? 2'h2 : 2'h1;
      default:
        code = (startup_time_fuses == 2'h0) ? 2'h0 : (startup_time_fuses == 2'h1) ? 2'h1 : 2'h2;
    endcase
    case (code)
      2'h1:    reset_delay = CNT_W'(WDOG_4K_CYCLES);
      2'h2:    reset_delay = CNT_W'(WDOG_64K_CYCLES);
      default: reset_delay = '0;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Fuse shadow
  // ----------------------------------------------------------------
  // Start-up states keep every domain gated and fetch held
  typedef enum logic [2:0] {
    ST_CAPTURE, ST_SRC_LOAD, ST_SRC_WAIT, ST_WD_LOAD, ST_WD_WAIT, ST_RUN, ST_SLEEP
  } cssc_state_t;

  // Fuse copies and sequencer bookkeeping
  cssc_state_t state;
  cssc_state_t next_state;
  logic [3:0]  fuse_sel;
  logic [1:0]  fuse_sut;
  logic        fuse_amp;
  logic        from_reset;
  logic        next_from_reset;
  logic [2:0]  sleep_mode_latched;

  // Factory values stand until the capture cycle right after reset
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      fuse_sel <= FACTORY_SOURCE_SELECT;
      fuse_sut <= FACTORY_STARTUP_TIME;
      fuse_amp <= FUSE_UNPROGRAMMED;
    end else if (state == ST_CAPTURE) begin
      fuse_sel <= i_clock_source_select_fuses;
      fuse_sut <= i_startup_time_fuses;
      fuse_amp <= i_oscillator_amplifier_option;
    end
  end

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  // Control fields and the one-cycle sleep command from the bus
  cssc_ctrl_t  ctrl;
  logic        sleep_request;
  logic [31:0] status_word;

  cssc_wb_regs u_regs (
    .i_clk           (i_clk),
    .i_rst           (i_rst),
    .i_wb_cyc        (i_wb_cyc),
    .i_wb_stb        (i_wb_stb),
    .i_wb_we         (i_wb_we),
    .i_wb_adr        (i_wb_adr),
    .i_wb_dat        (i_wb_dat),
    .i_wb_sel        (i_wb_sel),
    .i_status        (status_word),
    .o_wb_dat        (o_wb_dat),
    .o_wb_ack        (o_wb_ack),
    .o_ctrl          (ctrl),
    .o_sleep_request (sleep_request)
  );

  // ----------------------------------------------------------------
  // Start-up counters
  // ----------------------------------------------------------------
  // Delay values follow the captured fuses, never the live pins
  wire logic             src_load  = (state == ST_SRC_LOAD);
  wire logic             wd_load   = (state == ST_WD_LOAD);
  wire logic [CNT_W-1:0] src_value = source_delay(fuse_sel, fuse_sut);
  wire logic [CNT_W-1:0] wd_value  = reset_delay(fuse_sel, fuse_sut);
  logic                  src_done;
  logic                  wd_done;

  // Source cycles time oscillator settling after reset and deep wake
  cssc_startup_counter #(.W(CNT_W)) u_src_count (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_load  (src_load),
    .i_value (src_value),
    .i_tick  (i_source_tick),
    .o_done  (src_done)
  );

  // Watchdog cycles time the supply settling after reset only
  cssc_startup_counter #(.W(CNT_W)) u_wd_count (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_load  (wd_load),
    .i_value (wd_value),
    .i_tick  (i_watchdog_tick),
    .o_done  (wd_done)
  );

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------

  // Deep sleep stops the oscillator, so only those wakes recount
  wire logic deep_sleep = (sleep_mode_latched == SLEEP_POWER_DOWN) ||
                          (sleep_mode_latched == SLEEP_POWER_SAVE);

  // Next state
  always_comb begin
    next_state      = state;
    next_from_reset = from_reset;
    case (state)
      ST_CAPTURE: begin
        next_state      = ST_SRC_LOAD;
        next_from_reset = 1'b1;
      end
      ST_SRC_LOAD:
        next_state = ST_SRC_WAIT;
      ST_SRC_WAIT: begin
        if (src_done)
          next_state = from_reset ? ST_WD_LOAD : ST_RUN;
      end
      ST_WD_LOAD:
        next_state = ST_WD_WAIT;
      ST_WD_WAIT: begin
        if (wd_done)
          next_state = ST_RUN;
      end
      ST_RUN: begin
        next_from_reset = 1'b0;
        if (sleep_request)
          next_state = ST_SLEEP;
      end
      ST_SLEEP: begin
        if (i_wake_event)
          next_state = deep_sleep ? ST_SRC_LOAD : ST_RUN;
      end
      default:
        next_state = ST_CAPTURE;
    endcase
  end

  // State registers; mode is frozen on entry so a late write cannot reshape sleep
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state              <= ST_CAPTURE;
      from_reset         <= 1'b1;
      sleep_mode_latched <= CTRL_MODE_RESET;
    end else begin
      state      <= next_state;
      from_reset <= next_from_reset;
      if (state == ST_RUN && sleep_request)
        sleep_mode_latched <= ctrl.sleep_mode;
    end
  end

  // ----------------------------------------------------------------
  // Clock gating
  // ----------------------------------------------------------------
  // Domain groups; standby and reserved modes stop every domain
  wire logic running  = (state == ST_RUN);
  wire logic sleeping = (state == ST_SLEEP);
  wire logic in_idle  = sleeping && (sleep_mode_latched == SLEEP_IDLE);
  wire logic in_noise = sleeping && (sleep_mode_latched == SLEEP_NOISE_RED);
  wire logic in_psave = sleeping && (sleep_mode_latched == SLEEP_POWER_SAVE);
  wire logic int_rc   = (decode_source(fuse_sel) == SRC_INT_RC);

  // Per-domain enables; the timer shares the crystal pins, hence the source check
  cssc_clk_en_t next_clk_en;
  assign next_clk_en.core_clock           = running;
  assign next_clk_en.program_memory_clock = running;
  assign next_clk_en.peripheral_clock     = running || in_idle;
  assign next_clk_en.async_timer_clock    = ctrl.async_timer_enable && int_rc &&
                                            (running || in_idle || in_noise || in_psave);
  assign next_clk_en.converter_clock      = ctrl.converter_enable &&
                                            (running || in_idle || in_noise);

  // Registered so a gate never glitches on a decode transition
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_clk_en           <= '0;
      o_core_run         <= 1'b0;
      o_async_detect_arm <= 1'b0;
      o_source_kind      <= SRC_INT_RC;
      o_freq_range       <= RANGE_NONE;
    end else begin
      o_clk_en           <= next_clk_en;
      o_core_run         <= running;
      o_async_detect_arm <= sleeping;
      o_source_kind      <= decode_source(fuse_sel);
      o_freq_range       <= decode_range(fuse_sel, fuse_amp);
    end
  end

  // ----------------------------------------------------------------
  // Status word
  // ----------------------------------------------------------------

  // Live view of fuses, decode and sequencer for software
  // Bit 14 flags any start-up state, so polling software sees progress
  assign status_word = {16'h0000,
                        sleeping,
                        !(running || sleeping),
                        running,
                        o_freq_range,
                        o_source_kind,
                        fuse_amp,
                        fuse_sut,
                        fuse_sel};

endmodule // cssc_clock_control
`default_nettype wire

// ### dv/cssc_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module cssc_assertions
  import cssc_pkg::*;
(
  input wire logic         i_clk,              // Clock
  input wire logic         i_rst,              // Reset
  input wire logic         i_wb_cyc,           // Cycle
  input wire logic         i_wb_stb,           // Strobe
  input wire logic [31:0]  o_wb_dat,           // Read data
  input wire logic         o_wb_ack,           // Ack
  input wire cssc_clk_en_t o_clk_en,           // Enables
  input wire logic         o_core_run,         // Fetch on
  input wire logic         o_async_detect_arm, // Armed
  input wire cssc_source_t o_source_kind,      // Source
  input wire cssc_range_t  o_freq_range        // Range
);
  // ----------------------------------------
  // Checks, all in the system clock domain
  // ----------------------------------------
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  chk_fetch_held: assert property ($fell(i_rst) |-> !o_core_run [*4])
    else $error("fetch released too early");
  chk_async_src: assert property (o_clk_en.async_timer_clock |->
    o_source_kind == SRC_INT_RC) else $error("async clock off internal RC");
  chk_range_xtal: assert property (o_freq_range != RANGE_NONE |->
    o_source_kind == SRC_CRYSTAL) else $error("range without crystal");
  chk_sleep_core: assert property (o_async_detect_arm |->
    !o_core_run && !o_clk_en.core_clock) else $error("core active in sleep");
  chk_flash_core: assert property (o_clk_en.core_clock ==
    o_clk_en.program_memory_clock) else $error("flash and core clocks differ");
  chk_ack_next: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
    else $error("no ack one cycle after request");
  chk_ack_pulse: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack longer than one cycle");
  chk_dat_idle: assert property (!o_wb_ack |-> o_wb_dat == 32'h0000_0000)
    else $error("read data outside ack");
  // Fuse capture settles within three edges of release
  chk_fuse_hold: assert property ($past(!i_rst) && !$past(i_rst, 2) &&
    !$past(i_rst, 3) |-> $stable(o_source_kind)) else $error("source kind moved");
endmodule // cssc_assertions

bind cssc_clock_control cssc_assertions u_chk (.i_clk(i_clk), .i_rst(i_rst),
  .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack),
  .o_clk_en(o_clk_en), .o_core_run(o_core_run), .o_async_detect_arm(o_async_detect_arm),
  .o_source_kind(o_source_kind), .o_freq_range(o_freq_range));
`default_nettype wire

// ### dv/cssc_osc_model.sv
`timescale 1ns/1ns
`default_nettype none
module cssc_osc_model (
  input  wire logic       i_clk,          // System clock
  input  wire logic       i_rst,          // Sync reset
  input  wire logic [1:0] i_div,          // Source period minus one
  output logic            o_source_tick,  // Source cycle
  output logic            o_watchdog_tick // Watchdog cycle
);
  // ----------------------------------------
  // Oscillators
  // ----------------------------------------
  logic [1:0] cnt;
  // Slow source by gapped ticks, exposes counts taken in clk cycles
  always_ff @(posedge i_clk) begin
    if (i_rst || cnt == i_div) cnt <= 2'h0;
    else cnt <= cnt + 2'h1;
  end
  assign o_source_tick   = (cnt == 2'h0);
  assign o_watchdog_tick = !i_rst;
endmodule // cssc_osc_model
`default_nettype wire

// ### dv/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import cssc_pkg::*;
;
  // ----------------------------------------
  // Wiring
  // ----------------------------------------
  typedef struct packed {
    logic [3:0] sel;
    logic [1:0] startup_time_fuses;
    logic amp;
    logic [1:0] div;
    cssc_source_t kind;
    cssc_range_t rng;
    int s;
    int w;
  } cssc_row_t;
  cssc_row_t    rows [9];
  logic [2:0]   sm [5];
  logic [4:0]   se [5];
  logic         clk, rst, cyc, stb, we, wake, amp, st, wt, ack, run, arm;
  logic [3:0]   sel;
  logic [1:0]   startup_time_fuses, div;
  logic [7:0]   adr;
  logic [31:0]  wdat, rdat, dout;
  cssc_clk_en_t en;
  cssc_source_t kind;
  cssc_range_t  rng;
  int           failures, num_checks, c;

  cssc_clock_control #(.SRC_16K_CYCLES(40), .SRC_32K_CYCLES(50), .WDOG_4K_CYCLES(20),
    .WDOG_64K_CYCLES(30)) DUT (.i_clk(clk), .i_rst(rst), .i_clock_source_select_fuses(sel),
    .i_startup_time_fuses(startup_time_fuses), .i_oscillator_amplifier_option(amp), .i_source_tick(st),
    .i_watchdog_tick(wt), .i_wake_event(wake), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
    .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(4'hf), .o_wb_dat(dout), .o_wb_ack(ack),
    .o_clk_en(en), .o_core_run(run), .o_async_detect_arm(arm), .o_source_kind(kind),
    .o_freq_range(rng));
  cssc_osc_model u_osc (.i_clk(clk), .i_rst(rst), .i_div(div), .o_source_tick(st),
    .o_watchdog_tick(wt));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic summarize;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    num_checks++;
    if (s !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  // Bounded wait for fetch release, c counts cycles
  task automatic wait_run(output int n);
    n = 0;
    while (run !== 1'b1 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 3000) begin
      failures++;
      summarize();
    end
  endtask
  // Classic single cycle; data taken at the ack edge only
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    {cyc, stb, we, adr, wdat} <= {1'b1, 1'b1, w, a, d};
    @(posedge clk);
    while (ack !== 1'b1 && k < 20) begin
      @(posedge clk);
      k++;
    end
    rdat = dout;
    {cyc, stb, we} <= 3'h0;
    @(posedge clk);
    if (k >= 20) begin
      chk("ack", 1, 0);
      summarize();
    end
  endtask

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    clk = 0;
    forever #20 clk = ~clk;
  end
  initial begin
    failures = 0;
    num_checks = 0;
    {rst, cyc, stb, we, wake, adr, wdat, sel, startup_time_fuses, amp, div} = {1'b1, 53'h0};
    rows = '{'{4'ha, 2'h0, 1'h1, 2'h1, SRC_CRYSTAL, RANGE_0_4_TO_0_9, 258, 20},
      '{4'hd, 2'h1, 1'h1, 2'h0, SRC_CRYSTAL, RANGE_0_9_TO_3_0, 40, 0},
      '{4'hf, 2'h3, 1'h1, 2'h0, SRC_CRYSTAL, RANGE_3_0_TO_8_0, 40, 30},
      '{4'he, 2'h2, 1'h0, 2'h0, SRC_CRYSTAL, RANGE_1_0_UP, 1024, 0},
      '{4'hb, 2'h0, 1'h1, 2'h0, SRC_CRYSTAL, RANGE_0_4_TO_0_9, 1024, 30},
      '{4'h9, 2'h2, 1'h1, 2'h0, SRC_LOW_FREQ, RANGE_NONE, 50, 30},
      '{4'h7, 2'h3, 1'h1, 2'h0, SRC_EXT_RC, RANGE_NONE, 6, 20},
      '{4'h0, 2'h1, 1'h1, 2'h0, SRC_EXT_CLOCK, RANGE_NONE, 6, 20},
      '{4'h1, 2'h2, 1'h1, 2'h0, SRC_INT_RC, RANGE_NONE, 6, 30}};
    sm = '{SLEEP_IDLE, SLEEP_NOISE_RED, SLEEP_POWER_DOWN, SLEEP_POWER_SAVE, SLEEP_STANDBY};
    se = '{5'h0b, 5'h03, 5'h00, 5'h02, 5'h00};
    foreach (rows[i]) begin
      {sel, startup_time_fuses, amp, div} <= {rows[i].sel, rows[i].startup_time_fuses, rows[i].amp, rows[i].div};
      rst <= 1;
      repeat (2) @(posedge clk);
      rst <= 0;
      wait_run(c);
      chk("source", rows[i].kind, kind);
      chk("range", rows[i].rng, rng);
      c = c - rows[i].s * (rows[i].div + 1) - rows[i].w;
      chk("startup", 1, c >= -2 && c <= 10);
      $display("row %0d done", i);
    end
    wb(0, 8'h04, '0);
    chk("status", 32'h0000_21e1, rdat);
    wb(1, 8'h08, 32'h0000_0030);
    wb(0, 8'h08, '0);
    chk("unmapped", 0, rdat);
    wb(0, 8'h00, '0);
    chk("ctrl", 0, rdat);
    wb(1, 8'h00, 32'h0000_0030);
    chk("run_en", 5'h1f, en);
    $display("register tests done");
    for (int m = 0; m < 5; m++) begin
      wb(1, 8'h00, 32'h0000_0031 | (32'(sm[m]) << 1));
      repeat (3) @(posedge clk);
      chk("sleep_en", se[m], en);
      chk("armed", 1, arm);
      chk("halted", 0, run);
      wake <= 1;
      @(posedge clk);
      wake <= 0;
      wait_run(c);
      chk("wake", sm[m] == SLEEP_POWER_DOWN || sm[m] == SLEEP_POWER_SAVE, c > 4);
      chk("wake_len", 1, c <= 16);
      $display("sleep mode %0d done", sm[m]);
    end
    // Factory shadow at release, then pins ignored until the next reset
    {sel, startup_time_fuses, amp} <= 7'h00;
    rst <= 1;
    repeat (2) @(posedge clk);
    rst <= 0;
    wb(0, 8'h04, '0);
    chk("factory_stat", 32'h0000_41e1, rdat);
    wait_run(c);
    sel <= 4'hf;
    repeat (4) @(posedge clk);
    chk("fuse_hold", SRC_EXT_CLOCK, kind);
    wb(1, 8'h00, 32'h0000_0030);
    chk("no_async", 5'h1d, en);
    rst <= 1;
    repeat (2) @(posedge clk);
    chk("factory", SRC_INT_RC, kind);
    $display("fuse tests done");
    summarize();
  end
endmodule // tb_top
`default_nettype wire
